// File: design/lmcc_pkg.sv
// Constants and types shared by the logic mode clock control block.
//
// How it works
// RULE1 - Logic clock periods repeat at 1 MHz, counted from the system clock.
// RULE2 - A unit whose enable is low sees locked clocks and holds its state.
// RULE3 - Order: outputs lock, inputs unlock, inputs lock, outputs unlock.
// RULE4 - Master and slave stages never unlock together; guards separate them.
// RULE5 - An enabled unit advances once per period, at outputs unlock.
// RULE6 - Phase clocks toggle in RUN and in STOP step or burst periods, and reach units via enable gates.
// RULE7 - Exactly one of LOAD, RUN or STOP is active at all times.
// RULE8 - STOP holds the master phase clock high so nothing changes.
// RULE9 - LOAD holds the master phase clock high and asserts the load bus.
// RULE10 - In STOP each step press releases exactly one clock period.
// RULE11 - In STOP with burst input high, a step press runs until it drops.
// RULE12 - Two speed buttons select time scales of 1, 10, 100 and 1000.
// RULE13 - A reference timer on the slave phase makes six fixed pulse trains.
// RULE14 - Scaled trains equal fixed ones at X1 and speed up together.
// RULE15 - Each fixed pulse is high for exactly one whole clock period.
// RULE16 - The slowest fixed train is high one period in a million.
// RULE17 - Fixed trains step by decades from one in ten; plus constant one.
// RULE18 - Each scale step picks the train a decade faster, saturating at one.
// RULE19 - Mode changes take effect only at a period boundary.
// RULE20 - Step button is synchronised and debounced; one press, one action.
package lmcc_pkg;

  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned CLK_NS     = 25;
  localparam int unsigned LOGIC_HZ   = 1_000_000;
  localparam int unsigned PERIOD_CYC = CLK_HZ / LOGIC_HZ;
  localparam int unsigned GUARD_NS   = 25;
  localparam int unsigned SAMPLE_NS  = 75;
  localparam int unsigned GUARD_CYC  = (GUARD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [5:0] PH_LAST = 6'(PERIOD_CYC - 1);
  localparam logic [5:0] PH_T1   = 6'h00;
  localparam logic [5:0] PH_T2   = 6'(GUARD_CYC);
  localparam logic [5:0] PH_T3   = 6'(GUARD_CYC + SAMPLE_CYC);
  localparam logic [5:0] PH_T4   = 6'(2 * GUARD_CYC + SAMPLE_CYC);

  localparam int unsigned DEBOUNCE_US  = 5000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);

  localparam int unsigned N_DECADES = 6;
  localparam int unsigned RADIX     = 10;
  localparam int unsigned N_SCALED  = 4;
  localparam int unsigned SCALE_MAX = 3;

  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_PERIODS = 8'h08;

  localparam int unsigned CTRL_OVR    = 0;
  localparam int unsigned CTRL_TS_LSB = 1;
  localparam int unsigned CTRL_STEP   = 3;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;

  localparam int unsigned ST_MODE_LSB  = 0;
  localparam int unsigned ST_SCALE_LSB = 3;
  localparam int unsigned ST_BURST     = 5;
  localparam int unsigned ST_PEND      = 6;
  localparam int unsigned ST_RUNNING   = 7;

  typedef enum logic [2:0] {
    MODE_LOAD = 3'b001,
    MODE_RUN  = 3'b010,
    MODE_STOP = 3'b100
  } lmcc_mode_t;

  typedef enum logic [3:0] {
    GATE_IDLE  = 4'b0001,
    GATE_STEP  = 4'b0010,
    GATE_BURST = 4'b0100,
    GATE_RUN   = 4'b1000
  } lmcc_gate_t;

  typedef struct packed {
    logic                  one;
    logic [N_DECADES-1:0]  fixed;
    logic [N_SCALED-1:0]   scaled;
  } lmcc_trains_t;

endpackage : lmcc_pkg

// File: design/lmcc_debounce.sv
// Synchroniser and debouncer that turns a button into one press pulse.
`timescale 1ns/1ps
`default_nettype none
module lmcc_debounce #(
  parameter int unsigned CYCLES = lmcc_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Button and result
  input  wire logic raw,
  output logic      press
);
  localparam int unsigned W = $clog2(CYCLES + 1);

  logic         sync1;
  logic         sync2;
  logic         level;
  logic [W-1:0] cnt;
  logic         settle;

  assign settle = (cnt == W'(CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // The level changes only after the input has been steady for CYCLES.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= 1'b0;
      cnt   <= '0;
    end else if (sync2 == level) begin
      cnt <= '0;
    end else if (settle) begin
      level <= sync2; // [RULE20]
      cnt   <= '0;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      press <= 1'b0;
    end else begin
      press <= sync2 && !level && settle; // [RULE20]
    end
  end

  a_press_single: assert property (@(posedge clk) // [RULE20]
    disable iff (!rst_n) press |-> level ##1 !press)
    else $error("step press pulse longer than one cycle");

endmodule : lmcc_debounce
`default_nettype wire

// File: design/lmcc_decade.sv
// One decade stage of the reference timer.
`timescale 1ns/1ps
`default_nettype none
module lmcc_decade #(
  parameter int unsigned RADIX = lmcc_pkg::RADIX
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Chain
  input  wire logic advance,
  output logic      carry_out,
  output logic      next_zero
);
  localparam int unsigned W = $clog2(RADIX);

  logic [W-1:0] digit;
  logic         wrap;

  assign wrap      = (digit == W'(RADIX - 1));
  assign carry_out = advance && wrap;
  assign next_zero = advance ? wrap : (digit == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      digit <= '0;
    end else if (advance) begin
      digit <= wrap ? '0 : digit + W'(1); // [RULE17]
    end
  end

  a_digit_range: assert property (@(posedge clk) // [RULE17]
    disable iff (!rst_n) advance && wrap |=> digit == '0)
    else $error("decade stage did not wrap at its radix");

endmodule : lmcc_decade
`default_nettype wire

// File: design/lmcc_top.sv
// Logic mode, phase clock and timing pulse generation with an APB slave.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lmcc_top #(
  parameter int unsigned N_UNITS      = 8,
  parameter int unsigned DEBOUNCE_CYC = lmcc_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // APB slave
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Operator panel
  input  wire logic                   load_button,
  input  wire logic                   run_button,
  input  wire logic                   stop_button,
  input  wire logic                   step_button,
  input  wire logic                   speed_tenfold_button,
  input  wire logic                   speed_hundredfold_button,
  input  wire logic                   burst_step_input,
  // Clock distribution
  output logic                        master_phase_clock,
  output logic                        slave_phase_clock,
  output logic                        load_bus,
  // Clocked units
  input  wire logic [N_UNITS-1:0]     unit_enable,
  output logic [N_UNITS-1:0]          unit_master_clock,
  output logic [N_UNITS-1:0]          unit_slave_clock,
  output logic [N_UNITS-1:0]          unit_advance,
  // Timing pulse trains
  output lmcc_pkg::lmcc_trains_t      trains
);
  localparam int unsigned ND = lmcc_pkg::N_DECADES;
  localparam int unsigned NS = lmcc_pkg::N_SCALED;

  lmcc_pkg::lmcc_mode_t mode;
  lmcc_pkg::lmcc_mode_t next_mode;
  lmcc_pkg::lmcc_gate_t gate;
  lmcc_pkg::lmcc_gate_t next_gate;

  logic [5:0]         phase;
  logic               boundary;
  logic               running;
  logic               tick;
  logic               next_master;
  logic               next_slave;
  logic               step_press;
  logic               soft_step;
  logic               step_pend;
  logic [N_UNITS-1:0] en_q;
  logic [1:0]         panel_scale;
  logic [1:0]         next_scale;
  logic [1:0]         scale;
  logic               ts_override;
  logic [1:0]         ts_value;
  logic [31:0]        periods;
  logic [ND-1:0]      carry;
  logic [ND-1:0]      digit_zero;
  logic [ND-1:0]      next_fixed;
  logic [NS-1:0]      next_scaled;
  logic               apb_access;
  logic               apb_wr_ctrl;
  logic               mapped;

  // Period sequencer: one 1 MHz period every PERIOD_CYC system clocks.
  assign boundary = (phase == lmcc_pkg::PH_LAST);
  assign running  = (gate != lmcc_pkg::GATE_IDLE);
  assign tick     = running && (phase == lmcc_pkg::PH_T4);

  always_ff @(posedge clk) begin
    if (!rst_n || boundary) begin
      phase <= 6'h00; // [RULE1]
    end else begin
      phase <= phase + 6'h01;
    end
  end

  // Interlocked mode buttons; LOAD wins, then STOP, then RUN.
  always_comb begin
    next_mode = mode;
    if (load_button) begin
      next_mode = lmcc_pkg::MODE_LOAD;
    end else if (stop_button) begin
      next_mode = lmcc_pkg::MODE_STOP;
    end else if (run_button) begin
      next_mode = lmcc_pkg::MODE_RUN;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode     <= lmcc_pkg::MODE_LOAD;
      load_bus <= 1'b1;
    end else if (boundary) begin
      mode     <= next_mode; // [RULE7] [RULE19]
      load_bus <= (next_mode == lmcc_pkg::MODE_LOAD); // [RULE9]
    end
  end

  // Step button press and software step share one pending flag.
  lmcc_debounce #(
    .CYCLES (DEBOUNCE_CYC)
  ) u_step_debounce (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   (step_button),
    .press (step_press)
  );

  // A press in the boundary cycle survives and is served one period later.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_pend <= 1'b0;
    end else begin
      step_pend <= ((step_press || soft_step)
                    && (mode == lmcc_pkg::MODE_STOP)) // [RULE10]
                   || (step_pend && !boundary);
    end
  end

  // Clock gate decision, taken only at a period boundary.
  always_comb begin
    next_gate = lmcc_pkg::GATE_IDLE;
    case (next_mode)
      lmcc_pkg::MODE_RUN: begin
        next_gate = lmcc_pkg::GATE_RUN; // [RULE6]
      end
      lmcc_pkg::MODE_STOP: begin
        if (gate == lmcc_pkg::GATE_BURST && burst_step_input) begin
          next_gate = lmcc_pkg::GATE_BURST; // [RULE11]
        end else if (step_pend && burst_step_input) begin
          next_gate = lmcc_pkg::GATE_BURST; // [RULE11]
        end else if (step_pend) begin
          next_gate = lmcc_pkg::GATE_STEP; // [RULE10]
        end else begin
          next_gate = lmcc_pkg::GATE_IDLE; // [RULE8]
        end
      end
      default: begin
        next_gate = lmcc_pkg::GATE_IDLE; // [RULE9]
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate <= lmcc_pkg::GATE_IDLE;
    end else if (boundary) begin
      gate <= next_gate; // [RULE19]
    end
  end

  // Phase clocks: high means the stage is locked.
  assign next_slave  = running && (phase >= lmcc_pkg::PH_T1)
                       && (phase < lmcc_pkg::PH_T4); // [RULE3]
  assign next_master = !(running && (phase >= lmcc_pkg::PH_T2)
                       && (phase < lmcc_pkg::PH_T3)); // [RULE3] [RULE4]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      master_phase_clock <= 1'b1;
      slave_phase_clock  <= 1'b0;
    end else begin
      master_phase_clock <= next_master;
      slave_phase_clock  <= next_slave;
    end
  end

  // Unit enables are caught at the boundary so a unit sees whole periods.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q <= '0;
    end else if (boundary) begin
      en_q <= unit_enable; // [RULE2]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      unit_master_clock <= '1;
      unit_slave_clock  <= '1;
      unit_advance      <= '0;
    end else begin
      unit_master_clock <= {N_UNITS{next_master}} | ~en_q; // [RULE2] [RULE6]
      unit_slave_clock  <= {N_UNITS{next_slave}} | ~en_q; // [RULE2]
      unit_advance      <= {N_UNITS{tick}} & en_q; // [RULE5]
    end
  end

  // Time scale from the two speed buttons, or from software override.
  assign panel_scale = {speed_hundredfold_button,
                        speed_tenfold_button}; // [RULE12]
  assign next_scale  = ts_override ? ts_value : panel_scale;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scale <= 2'h0;
    end else if (boundary) begin
      scale <= next_scale;
    end
  end

  // Reference timer, advanced by each slave phase unlock.
  assign carry[0] = tick; // [RULE13]

  for (genvar k = 0; k < ND; k++) begin : g_decade
    if (k < ND - 1) begin : g_mid
      lmcc_decade #(
        .RADIX (lmcc_pkg::RADIX)
      ) u_decade (
        .clk       (clk),
        .rst_n     (rst_n),
        .advance   (carry[k]),
        .carry_out (carry[k+1]),
        .next_zero (digit_zero[k])
      );
    end else begin : g_last
      lmcc_decade #(
        .RADIX (lmcc_pkg::RADIX)
      ) u_decade (
        .clk       (clk),
        .rst_n     (rst_n),
        .advance   (carry[k]),
        .carry_out (),
        .next_zero (digit_zero[k])
      );
    end
  end

  // Train k is high when the k+1 lowest digits are all zero.
  always_comb begin
    next_fixed[0] = digit_zero[0]; // [RULE17]
    for (int k = 1; k < ND; k++) begin
      next_fixed[k] = next_fixed[k-1] && digit_zero[k]; // [RULE16] [RULE17]
    end
  end

  // Scaled train j picks the fixed train scale decades faster.
  always_comb begin
    logic [ND:0] ladder;
    ladder = {next_fixed, 1'b1};
    for (int j = 0; j < NS; j++) begin
      next_scaled[j] = ladder[j + lmcc_pkg::SCALE_MAX
                              - 32'(next_scale)]; // [RULE14] [RULE18]
    end
  end

  // Fixed trains change only with the timer, so each pulse spans a whole period; scaled trains also switch when next_scale does.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trains <= '0;
    end else begin
      trains.one    <= 1'b1; // [RULE17]
      trains.fixed  <= next_fixed; // [RULE13] [RULE15]
      trains.scaled <= next_scaled; // [RULE14]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      periods <= 32'h0000_0000;
    end else if (tick) begin
      periods <= periods + 32'h0000_0001;
    end
  end

  // APB slave with no wait states.
  assign apb_access  = psel && penable;
  assign apb_wr_ctrl = apb_access && pwrite && (paddr == lmcc_pkg::REG_CTRL);
  assign soft_step   = apb_wr_ctrl && pwdata[lmcc_pkg::CTRL_STEP];
  assign pready      = 1'b1;
  assign pslverr     = apb_access && !mapped;

  always_comb begin
    if (paddr == lmcc_pkg::REG_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == lmcc_pkg::REG_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == lmcc_pkg::REG_PERIODS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {ts_value, ts_override} <= lmcc_pkg::CTRL_RESET;
    end else if (apb_wr_ctrl) begin
      ts_override <= pwdata[lmcc_pkg::CTRL_OVR];
      ts_value    <= pwdata[lmcc_pkg::CTRL_TS_LSB +: 2];
    end
  end

  // Read data is latched in the setup cycle and held through the access.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == lmcc_pkg::REG_CTRL) begin
        prdata[lmcc_pkg::CTRL_OVR]         <= ts_override;
        prdata[lmcc_pkg::CTRL_TS_LSB +: 2] <= ts_value;
      end else if (paddr == lmcc_pkg::REG_STATUS) begin
        prdata[lmcc_pkg::ST_MODE_LSB +: 3]  <= mode;
        prdata[lmcc_pkg::ST_SCALE_LSB +: 2] <= scale;
        prdata[lmcc_pkg::ST_BURST] <= (gate == lmcc_pkg::GATE_BURST);
        prdata[lmcc_pkg::ST_PEND]           <= step_pend;
        prdata[lmcc_pkg::ST_RUNNING]        <= running;
      end else if (paddr == lmcc_pkg::REG_PERIODS) begin
        prdata <= periods;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_no_overlap: assert property ( // [RULE4]
    master_phase_clock || slave_phase_clock)
    else $error("master and slave stages unlocked together");

  a_phase_order: assert property ( // [RULE3]
    $rose(slave_phase_clock) |-> ##1 $fell(master_phase_clock)
      ##3 $rose(master_phase_clock) ##1 $fell(slave_phase_clock))
    else $error("phase clock edges out of order or mistimed");

  a_stop_holds: assert property ( // [RULE8]
    mode == lmcc_pkg::MODE_STOP && gate == lmcc_pkg::GATE_IDLE
      && phase != lmcc_pkg::PH_T1 |-> master_phase_clock)
    else $error("master phase clock unlocked while stopped");

  a_load_bus: assert property ( // [RULE9]
    mode == lmcc_pkg::MODE_LOAD |-> load_bus && !running)
    else $error("load mode without load bus or with clocks");

  a_mode_onehot: assert property ( // [RULE7]
    $onehot(mode))
    else $error("logic mode is not exactly one of three");

  a_run_toggles: assert property ( // [RULE6]
    boundary && mode == lmcc_pkg::MODE_RUN && next_mode == mode
      |-> ##[1:8] !master_phase_clock)
    else $error("phase clocks idle in run mode");

  a_step_single: assert property ( // [RULE10]
    gate == lmcc_pkg::GATE_STEP && boundary && !step_pend
      |=> gate != lmcc_pkg::GATE_STEP)
    else $error("single step released more than one period");

  a_mode_boundary: assert property ( // [RULE19]
    !$past(boundary) |-> $stable(mode) && $stable(gate))
    else $error("mode changed inside a clock period");

  a_pulse_width: assert property ( // [RULE15]
    mode == lmcc_pkg::MODE_RUN && $rose(trains.fixed[0]) |-> trains.fixed[0]
      [*8] ##32 trains.fixed[0] ##1 (!trains.fixed[0] || !running))
    else $error("fixed pulse not one full period wide");

  a_unit_gate: assert property ( // [RULE2]
    !en_q[N_UNITS-1] |=> unit_master_clock[N_UNITS-1]
      && unit_slave_clock[N_UNITS-1] && !unit_advance[N_UNITS-1])
    else $error("disabled unit received a clock");
endmodule : lmcc_top
`default_nettype wire

// File: testbench/lmcc_units.sv
// Model of patched clocked counters and of a burst-length counter.
`timescale 1ns/1ps
`default_nettype none
module lmcc_units #(
  parameter int unsigned N = 8
) (
  // Clock
  input  wire logic              clk,
  // Clock distribution
  input  wire logic              load_bus,
  input  wire logic              master_phase_clock,
  input  wire logic [N-1:0]      unit_master_clock,
  input  wire logic [N-1:0]      unit_slave_clock,
  // Burst control
  input  wire logic [7:0]        burst_len,
  input  wire logic              burst_arm,
  output logic                   burst_step_input,
  // Unit state
  output logic [N-1:0][7:0]      cnt
);
  logic [N-1:0][7:0] mst;
  logic [7:0]        left;
  logic              mpc_q;

  // Each unit is a counter built of a master and a slave stage.
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (load_bus) begin
        mst[i] <= 8'h00;
        cnt[i] <= 8'h00;
      end else begin
        if (!unit_master_clock[i]) mst[i] <= cnt[i] + 8'h01;
        if (!unit_slave_clock[i]) cnt[i] <= mst[i];
      end
    end
  end

  // The burst line drops after the armed number of issued periods.
  always_ff @(posedge clk) begin
    mpc_q <= master_phase_clock;
    if (burst_arm) begin
      left <= burst_len;
    end else if (mpc_q && !master_phase_clock && left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign burst_step_input = (left != 8'h00);
endmodule : lmcc_units
`default_nettype wire

// File: testbench/lmcc_top_tb.sv
// Bench for the logic mode clock control block and its patched units.
`timescale 1ns/1ps
`default_nettype none
module lmcc_top_tb;
  logic                   clk, rst_n, psel, penable, pwrite, pready;
  logic                   pslverr, load_bus, burst_arm, er;
  logic                   load_button, run_button, stop_button;
  logic                   step_button, burst_step_input;
  logic                   speed_tenfold_button, speed_hundredfold_button;
  logic                   master_phase_clock, slave_phase_clock;
  logic [7:0]             paddr, burst_len, c0, adv;
  logic [31:0]            pwdata, prdata, rd;
  logic [7:0]             unit_enable, unit_master_clock, unit_slave_clock;
  logic [7:0][7:0]        cnt;
  lmcc_pkg::lmcc_trains_t trains;
  int                     err_count, checked, falls;
  int                     hi [6];

  lmcc_top #(.N_UNITS(8), .DEBOUNCE_CYC(4)) DUT (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_button(load_button), .run_button(run_button),
    .stop_button(stop_button), .step_button(step_button),
    .speed_tenfold_button(speed_tenfold_button),
    .speed_hundredfold_button(speed_hundredfold_button),
    .burst_step_input(burst_step_input),
    .master_phase_clock(master_phase_clock),
    .slave_phase_clock(slave_phase_clock), .load_bus(load_bus),
    .unit_enable(unit_enable), .unit_master_clock(unit_master_clock),
    .unit_slave_clock(unit_slave_clock), .unit_advance(adv), .trains(trains)
  );
  lmcc_units #(.N(8)) units (
    .clk(clk), .load_bus(load_bus), .master_phase_clock(master_phase_clock),
    .unit_master_clock(unit_master_clock),
    .unit_slave_clock(unit_slave_clock), .burst_len(burst_len),
    .burst_arm(burst_arm), .burst_step_input(burst_step_input), .cnt(cnt)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge master_phase_clock) falls++;
  // Both stages open together would let data race through a unit.
  always @(negedge clk) begin
    if (rst_n === 1'b1 && master_phase_clock === 1'b0 &&
        slave_phase_clock === 1'b0) fail("stages open");
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic fail(input string m);
    err_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checked++;
    if (g !== e) fail($sformatf("%s got %h exp %h", m, g, e));
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail("no ready");
      end_sim();
    end
    @(posedge clk);
  endtask : apb
  task automatic mode(input int b);
    load_button <= (b == 0);
    stop_button <= (b == 1);
    run_button  <= (b == 2);
    cyc(41);
    {load_button, stop_button, run_button} <= 3'h0;
    cyc(40);
  endtask : mode
  task automatic step(input int hold);
    step_button <= 1'b1;
    cyc(hold);
    step_button <= 1'b0;
    cyc(400);
  endtask : step
  task automatic measure(input int n);
    for (int k = 0; k < 6; k++) hi[k] = 0;
    falls = 0;
    repeat (n) begin
      @(negedge clk);
      hi[0] += trains.fixed[0];
      hi[1] += trains.fixed[1];
      hi[2] += trains.scaled[0];
      hi[3] += trains.scaled[1];
      hi[4] += trains.one;
      hi[5] += adv[0] + 16 * adv[4];
    end
    @(posedge clk);
  endtask : measure
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {load_button, run_button, stop_button, step_button} = 4'h0;
    {speed_tenfold_button, speed_hundredfold_button} = 2'h0;
    unit_enable = 8'h0f;
    burst_len = 8'h00;
    burst_arm = 1'b1;
    {err_count, checked, falls} = '0;
    cyc(3);
    rst_n     <= 1'b1;
    burst_arm <= 1'b0;
    cyc(2);
    apb(1'b1, 8'h04, 32'hffffffff);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h7, 32'h1, "load mode");
    chk(load_bus, 1'b1, "load bus");
    apb(1'b0, 8'h0c, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");
    mode(2);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h87, 32'h82, "run status");
    c0 = cnt[0];
    measure(400);
    chk(falls, 32'h0a, "run falls");
    chk(8'(cnt[0] - c0), 32'h0a, "unit steps");
    chk(hi[5], 32'h0a, "advance pulses");
    chk(cnt[4], 8'h00, "disabled unit");
    chk(unit_master_clock[7:4], 4'hf, "gated clock");
    for (int s = 0; s < 4; s++) begin
      speed_tenfold_button     <= s[0];
      speed_hundredfold_button <= s[1];
      cyc(80);
      apb(1'b0, 8'h04, 32'h0);
      chk((rd >> 3) & 32'h3, 32'(s), "scale");
      measure(4000);
      chk(hi[0], 32'h190, "fast train");
      chk(hi[1], 32'h28, "second train");
      chk(hi[4], 32'hfa0, "one");
      if (s >= 1) chk(hi[2], 32'h28 * 10 ** (s-1), "v0");
      if (s >= 2) chk(hi[3], 32'h28 * 10 ** (s-2), "v1");
    end
    $display("test run done");
    mode(1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h7, 32'h4, "stop mode");
    c0 = cnt[0];
    measure(400);
    chk(falls, 32'h0, "stop falls");
    chk(hi[5], 32'h0, "stop advance");
    chk(master_phase_clock, 1'b1, "stop lock");
    chk(cnt[0], c0, "stop hold");
    falls = 0;
    step(200);
    chk(falls, 32'h1, "long press");
    chk(8'(cnt[0] - c0), 32'h1, "step unit");
    apb(1'b1, 8'h00, 32'h8);
    cyc(120);
    chk(8'(cnt[0] - c0), 32'h2, "soft step");
    $display("test step done");
    c0 = cnt[0];
    falls = 0;
    burst_len <= 8'h05;
    burst_arm <= 1'b1;
    cyc(1);
    burst_arm <= 1'b0;
    step(20);
    chk(falls, 32'h5, "burst falls");
    chk(8'(cnt[0] - c0), 32'h5, "burst unit");
    $display("test burst done");
    mode(0);
    chk({load_bus, master_phase_clock}, 2'h3, "load");
    chk(cnt[0], 8'h00, "load state");
    falls = 0;
    step(20);
    chk(falls, 32'h0, "load step");
    $display("test load done");
    end_sim();
  end
endmodule : lmcc_top_tb
`default_nettype wire
